// >>> bench/iat_partner.sv
`default_nettype none
module iat_partner (
	// Clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rst,
	// Bench controls
	input  wire logic                 reqOn,
	input  wire logic [3:0]           reqLevel,
	input  wire iat_pkg::iat_src_e    reqSrc,
	input  wire logic                 doneEvery,
	input  wire iat_pkg::iat_instr_s  shape,
	// Design side
	input  wire logic                 saveStrobe,
	output var iat_pkg::iat_req_s     req,
	output var iat_pkg::iat_instr_s   instr
);
	timeunit 1ns;
	timeprecision 100ps;

	logic served;

	// Controller withdraws its request once the CPU has taken it
	always_ff @(posedge core_clk) begin
		if (rst || !reqOn) begin
			served <= 1'b0;
		end else if (saveStrobe) begin
			served <= 1'b1;
		end
	end

	always_comb begin
		req.valid = reqOn && !served;
		// Idle level lines show the inverse so a stale value never matches
		req.level = (reqOn && !served) ? reqLevel : ~reqLevel;
		req.source = reqSrc;
		instr = shape;
		// Held high models a stream of one-state instructions
		instr.done = doneEvery;
	end
endmodule : iat_partner
`default_nettype wire

// >>> bench/interrupt_acceptance_timing_tb_top.sv
`default_nettype none
module interrupt_acceptance_timing_tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	logic                  core_clk, rst, reqOn, doneEvery;
	logic                  saveStrobe, fetchValid;
	logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic                  s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic                  s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic                  s_axi_rready;
	logic [1:0]            s_axi_bresp, s_axi_rresp, rr;
	logic [3:0]            reqLevel, s_axi_wstrb;
	logic [7:0]            s_axi_awaddr, s_axi_araddr;
	logic [31:0]           s_axi_wdata, s_axi_rdata, rd;
	logic [31:0]           pcIn, fetchAddr, statusWord, vbase;
	iat_pkg::iat_src_e     reqSrc;
	iat_pkg::iat_instr_s   shape, instr;
	iat_pkg::iat_req_s     req;
	int                    badCount, checksDone, n, s, i, e, w;
	iat_pkg::iat_src_e     srcs[3];
	int                    halfs[3];

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	iat_interrupt_accept dut (
		.core_clk, .rst, .req, .instr, .pcIn,
		.saveStrobe, .fetchValid, .fetchAddr, .statusWord,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
	);

	iat_partner far (
		.core_clk, .rst, .reqOn, .reqLevel, .reqSrc, .doneEvery,
		.shape, .saveStrobe, .req, .instr
	);

	task automatic check(input string what, input logic [31:0] exp,
			input logic [31:0] got);
		checksDone++;
		if (got !== exp) begin
			badCount++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic tallyAndFinish;
		$display("checks %0d mismatches %0d", checksDone, badCount);
		if (badCount == 0 && checksDone > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : tallyAndFinish

	task automatic hang(input string what);
		badCount++;
		$display("wrong value %s expected answer seen none", what);
		tallyAndFinish();
	endtask : hang

	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (k = 0; k < 40; k++) begin
			@(posedge core_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				rr = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
		end
		if (k == 40) hang("write response");
	endtask : axiWrite

	task automatic axiRead(input logic [7:0] a);
		int k;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (k = 0; k < 40; k++) begin
			@(posedge core_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				rd = s_axi_rdata;
				rr = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
		end
		if (k == 40) hang("read data");
	endtask : axiRead

	// Counts no save strobe while a request is pending but must be held
	task automatic quiet(input int cycles);
		int k, seen;
		seen = 0;
		for (k = 0; k < cycles; k++) begin
			@(posedge core_clk);
			if (saveStrobe !== 1'b0) seen++;
		end
		check("saves while held off", 0, seen);
	endtask : quiet

	// Returns edges from request to sampled save strobe
	task automatic takeIrq(input iat_pkg::iat_src_e sr, input logic [3:0] lv,
			output int cnt);
		int m;
		@(posedge core_clk);
		reqSrc <= sr;
		reqLevel <= lv;
		reqOn <= 1'b1;
		cnt = 0;
		do begin
			@(posedge core_clk);
			cnt++;
		end while (saveStrobe !== 1'b1 && cnt < 200);
		if (cnt == 200) hang("save strobe");
		for (m = 0; m < 20 && fetchValid !== 1'b1; m++) @(posedge core_clk);
		if (m == 20) hang("fetch strobe");
		check("save to fetch cycles", 5, m);
		check("handler address", vbase + iat_pkg::INT_OFFSET,
			fetchAddr);
		reqOn <= 1'b0;
	endtask : takeIrq

	initial begin
		rst = 1'b1;
		reqOn = 1'b0;
		reqLevel = 4'h0;
		reqSrc = iat_pkg::SRC_NMI;
		doneEvery = 1'b1;
		shape = '0;
		pcIn = 32'h0c001234;
		vbase = 32'h8c000000;
		s_axi_awaddr = '0;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'hf;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = '0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		badCount = 0;
		checksDone = 0;
		srcs = '{iat_pkg::SRC_NMI, iat_pkg::SRC_LEVEL, iat_pkg::SRC_MODULE};
		halfs[0] = iat_pkg::HALF_ICYC + iat_pkg::HALF_NMI;
		halfs[1] = iat_pkg::HALF_ICYC + iat_pkg::HALF_LEVEL;
		halfs[2] = iat_pkg::HALF_ICYC + iat_pkg::HALF_MODULE;
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;

		axiRead(iat_pkg::OFF_STATUS);
		check("status reset", iat_pkg::SW_RESET, rd);
		axiRead(iat_pkg::OFF_VBASE);
		check("vector base reset", iat_pkg::VBASE_RESET, rd);
		axiRead(8'h20);
		check("unmapped read resp", iat_pkg::RESP_SLVERR, rr);
		check("unmapped read data", 32'h0, rd);
		axiWrite(iat_pkg::OFF_VBASE, vbase);
		check("write resp", iat_pkg::RESP_OKAY, rr);
		axiWrite(8'h20, 32'h00000000);
		check("unmapped write resp", iat_pkg::RESP_SLVERR, rr);
		axiRead(iat_pkg::OFF_VBASE);
		check("vector base", vbase, rd);
		check("read resp", iat_pkg::RESP_OKAY, rr);
		$display("test registers done");

		// Block flag set with a low mask: a request above it must still wait
		axiWrite(iat_pkg::OFF_STATUS, 32'h10000030);
		@(posedge core_clk);
		reqLevel <= 4'hf;
		reqOn <= 1'b1;
		quiet(30);
		axiRead(iat_pkg::OFF_ACCEPT);
		check("held state", 32'(iat_pkg::ST_WAITEND), 32'(rd[2:0]));
		reqOn <= 1'b0;
		axiWrite(iat_pkg::OFF_STATUS, 32'h00000030);
		takeIrq(iat_pkg::SRC_NMI, 4'hf, n);
		check("status after accept", 32'h70000030, statusWord);
		axiRead(iat_pkg::OFF_SAVED_SW);
		check("saved status", 32'h00000030, rd);
		axiRead(iat_pkg::OFF_SAVED_PC);
		check("saved pc", pcIn, rd);
		$display("test block flag done");

		for (i = 0; i < 3; i++) begin
			axiWrite(iat_pkg::OFF_STATUS, 32'h0);
			takeIrq(srcs[i], 4'h1, n);
			check("decision latency", 32'((halfs[i] + 1) / 2 + 3), n);
		end
		$display("test sources done");

		axiWrite(iat_pkg::OFF_STATUS, 32'h00000050);
		@(posedge core_clk);
		reqSrc <= iat_pkg::SRC_LEVEL;
		reqLevel <= 4'h5;
		reqOn <= 1'b1;
		quiet(40);
		takeIrq(iat_pkg::SRC_LEVEL, 4'h6, n);
		$display("test mask level done");

		// Instruction never ends on its own, so the state bound decides
		doneEvery <= 1'b0;
		// Last pass is the status load on a cache hit, with no extra states
		for (i = 0; i < 3; i++) begin
			e = (i == 2) ? 0 : i + 1;
			w = (i == 2) ? 0 : 2 - i;
			shape.statusLoad <= (i != 0);
			shape.extAccesses <= 2'(e);
			shape.baseStates <= 4'h3;
			shape.memWait <= 4'(w);
			s = (i == 0) ? 3 : int'(iat_pkg::STATUS_LOAD_STATES);
			s = s + e * int'(iat_pkg::EXT_ACCESS_STATES) + w;
			axiWrite(iat_pkg::OFF_STATUS, 32'h0);
			takeIrq(iat_pkg::SRC_NMI, 4'h1, n);
			axiRead(iat_pkg::OFF_ACCEPT);
			check("wait count", 32'(s - 1), 32'(rd[13:8]));
			check("wait bounded", 1, 32'(n <= s + 5));
		end
		$display("test wait bound done");
		tallyAndFinish();
	end
endmodule : interrupt_acceptance_timing_tb_top
`default_nettype wire

// >>> rtl/iat_axil_slave.sv
`default_nettype none
module iat_axil_slave (
	// Clock and reset
	input  wire logic                       core_clk,
	input  wire logic                       rst,
	// AXI4-Lite write
	input  wire logic [iat_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	// AXI4-Lite read
	input  wire logic [iat_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	// Register side
	output logic                            wrEn,
	output logic [iat_pkg::ADDR_W-1:0]      wrAddr,
	output logic [31:0]                     wrData,
	output logic [3:0]                      wrStrb,
	input  wire logic                       wrOk,
	output logic [iat_pkg::ADDR_W-1:0]      rdAddr,
	input  wire logic [31:0]                rdData,
	input  wire logic                       rdOk
);
	logic awHeld, next_awHeld, wHeld, next_wHeld, rdPend, next_rdPend;
	logic next_awready, next_wready, next_arready, next_wrEn;
	logic next_bvalid, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_wrData, next_rdata;
	logic [3:0] next_wrStrb;
	logic [iat_pkg::ADDR_W-1:0] next_wrAddr, next_rdAddr;

	always_comb begin
		next_awHeld = awHeld;
		next_wHeld = wHeld;
		next_wrAddr = wrAddr;
		next_wrData = wrData;
		next_wrStrb = wrStrb;
		next_wrEn = 1'b0;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		next_rdPend = rdPend;
		next_rdAddr = rdAddr;
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_awvalid && s_axi_awready) begin
			next_awHeld = 1'b1;
			next_wrAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_wHeld = 1'b1;
			next_wrData = s_axi_wdata;
			next_wrStrb = s_axi_wstrb;
		end
		// Address and data may arrive in either order
		if (awHeld && wHeld && !wrEn) begin
			next_wrEn = 1'b1;
		end
		if (wrEn) begin
			next_awHeld = 1'b0;
			next_wHeld = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = wrOk ? iat_pkg::RESP_OKAY : iat_pkg::RESP_SLVERR;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rdPend = 1'b1;
			next_rdAddr = s_axi_araddr;
		end
		if (rdPend) begin
			next_rdPend = 1'b0;
			next_rvalid = 1'b1;
			next_rdata = rdOk ? rdData : 32'h00000000;
			next_rresp = rdOk ? iat_pkg::RESP_OKAY : iat_pkg::RESP_SLVERR;
		end
		if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		// One write and one read in flight at a time
		next_awready = !next_awHeld && !next_bvalid && !next_wrEn;
		next_wready = !next_wHeld && !next_bvalid && !next_wrEn;
		next_arready = !next_rdPend && !next_rvalid;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			wrEn <= 1'b0;
			wrAddr <= '0;
			wrData <= 32'h00000000;
			wrStrb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			rdPend <= 1'b0;
			rdAddr <= '0;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end else begin
			awHeld <= next_awHeld;
			wHeld <= next_wHeld;
			wrEn <= next_wrEn;
			wrAddr <= next_wrAddr;
			wrData <= next_wrData;
			wrStrb <= next_wrStrb;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			rdPend <= next_rdPend;
			rdAddr <= next_rdAddr;
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end
endmodule : iat_axil_slave
`default_nettype wire

// >>> rtl/iat_interrupt_accept.sv
// Contract
// - While the block flag is set, hold off handling until it clears.
// - Decision takes half a CPU cycle plus bus/peripheral terms by source.
// - Start handling only after the executing instruction has finished.
// - Wait for instruction end is at most its state count minus one.
// - Handler fetch starts five CPU cycles after status and PC save.
// - Instruction state count includes its memory access wait cycles.
// - Status load post-increment takes seven states plus external accesses.
// - Forward a request only if its level exceeds the status mask level.
// - On acceptance save status and PC, then set block, mode, bank bits.
// - Fetch at vector base plus fixed offset; mask level left unchanged.
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`default_nettype none
module iat_interrupt_accept (
	// Clock and reset
	input  wire logic                       core_clk,
	input  wire logic                       rst,
	// Interrupt controller and pipeline
	input  wire iat_pkg::iat_req_s          req,
	input  wire iat_pkg::iat_instr_s        instr,
	input  wire logic [31:0]                pcIn,
	// Handler fetch and status to the pipeline
	output logic                            saveStrobe,
	output logic                            fetchValid,
	output logic [31:0]                     fetchAddr,
	output logic [31:0]                     statusWord,
	// AXI4-Lite
	input  wire logic [iat_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [iat_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready
);
	function automatic logic [7:0] decideCycles(iat_pkg::iat_src_e src);
		int unsigned h;
		h = iat_pkg::HALF_ICYC;
		case (src)
			iat_pkg::SRC_NMI: h = h + iat_pkg::HALF_NMI;
			iat_pkg::SRC_LEVEL: h = h + iat_pkg::HALF_LEVEL;
			default: h = h + iat_pkg::HALF_MODULE;
		endcase
		// Half cycles round up to whole CPU cycles
		decideCycles = 8'((h + 1) / 2);
	endfunction : decideCycles

	function automatic logic [5:0] effStates(iat_pkg::iat_instr_s i);
		logic [5:0] base;
		base = i.statusLoad ? iat_pkg::STATUS_LOAD_STATES
			: {2'h0, i.baseStates};
		effStates = base + 6'(i.extAccesses) * iat_pkg::EXT_ACCESS_STATES
			+ {2'h0, i.memWait};
	endfunction : effStates

	function automatic logic isMapped(logic [iat_pkg::ADDR_W-1:0] a);
		case (a)
			iat_pkg::OFF_STATUS, iat_pkg::OFF_VBASE, iat_pkg::OFF_SAVED_SW,
			iat_pkg::OFF_SAVED_PC, iat_pkg::OFF_ACCEPT: isMapped = 1'b1;
			default: isMapped = 1'b0;
		endcase
	endfunction : isMapped

	function automatic logic [31:0] mergeBytes(logic [31:0] old,
			logic [31:0] data, logic [3:0] strb);
		mergeBytes = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				mergeBytes[b*8 +: 8] = data[b*8 +: 8];
			end
		end
	endfunction : mergeBytes

	iat_pkg::iat_state_e state, next_state;
	iat_pkg::iat_src_e srcHeld, next_srcHeld;
	logic [7:0] cnt, next_cnt;
	logic [5:0] waitCnt, next_waitCnt, limit, next_limit;
	logic [5:0] lastWait, next_lastWait;
	logic [31:0] next_statusWord, vectorBase, next_vectorBase;
	logic [31:0] savedStatus, next_savedStatus, savedPc, next_savedPc;
	logic [31:0] next_fetchAddr, rdData;
	logic next_fetchValid, next_saveStrobe;
	logic wrEn, blockFlag, above, instrEnds;
	logic [iat_pkg::ADDR_W-1:0] wrAddr, rdAddr;
	logic [31:0] wrData;
	logic [3:0] wrStrb;
	logic [iat_pkg::IMASK_W-1:0] maskLevel;

	iat_axil_slave u_bus (
		.core_clk      (core_clk),
		.rst           (rst),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wrEn          (wrEn),
		.wrAddr        (wrAddr),
		.wrData        (wrData),
		.wrStrb        (wrStrb),
		.wrOk          (isMapped(wrAddr)),
		.rdAddr        (rdAddr),
		.rdData        (rdData),
		.rdOk          (isMapped(rdAddr))
	);

	assign blockFlag = statusWord[iat_pkg::SW_BL_BIT];
	assign maskLevel = statusWord[iat_pkg::SW_IMASK_LSB +: iat_pkg::IMASK_W];
	assign above = req.valid && (req.level > maskLevel);
	// The boundary is either the reported end or the last counted state
	assign instrEnds = instr.done || (waitCnt >= limit);

	always_comb begin
		rdData = 32'h00000000;
		case (rdAddr)
			iat_pkg::OFF_STATUS: rdData = statusWord;
			iat_pkg::OFF_VBASE: rdData = vectorBase;
			iat_pkg::OFF_SAVED_SW: rdData = savedStatus;
			iat_pkg::OFF_SAVED_PC: rdData = savedPc;
			iat_pkg::OFF_ACCEPT: begin
				rdData[iat_pkg::ACC_STATE_LSB +: 3] = state;
				rdData[iat_pkg::ACC_WAIT_LSB +: 6] = lastWait;
			end
			default: rdData = 32'h00000000;
		endcase
	end

	always_comb begin
		next_state = state;
		next_srcHeld = srcHeld;
		next_cnt = cnt;
		next_waitCnt = waitCnt;
		next_limit = limit;
		next_lastWait = lastWait;
		next_statusWord = statusWord;
		next_vectorBase = vectorBase;
		next_savedStatus = savedStatus;
		next_savedPc = savedPc;
		next_fetchAddr = fetchAddr;
		next_fetchValid = 1'b0;
		if (wrEn && wrAddr == iat_pkg::OFF_STATUS) begin
			next_statusWord = mergeBytes(statusWord, wrData, wrStrb);
		end
		if (wrEn && wrAddr == iat_pkg::OFF_VBASE) begin
			next_vectorBase = mergeBytes(vectorBase, wrData, wrStrb);
		end
		case (state)
			iat_pkg::ST_IDLE: begin
				if (above) begin
					next_state = iat_pkg::ST_DECIDE;
					next_srcHeld = req.source;
					next_cnt = decideCycles(req.source) - 8'h01;
				end
			end
			iat_pkg::ST_DECIDE: begin
				if (cnt != 8'h00) begin
					next_cnt = cnt - 8'h01;
				end else if (above) begin
					next_state = iat_pkg::ST_WAITEND;
					next_waitCnt = 6'h00;
					next_limit = effStates(instr) - 6'h01;
				end else begin
					next_state = iat_pkg::ST_IDLE;
				end
			end
			iat_pkg::ST_WAITEND: begin
				if (!above) begin
					// Withdrawn or now masked; the controller keeps it pending
					next_state = iat_pkg::ST_IDLE;
				end else if (blockFlag) begin
					next_waitCnt = 6'h00;
					next_limit = effStates(instr) - 6'h01;
				end else if (instrEnds) begin
					next_state = iat_pkg::ST_SAVE;
					next_lastWait = waitCnt;
				end else begin
					next_waitCnt = waitCnt + 6'h01;
				end
			end
			iat_pkg::ST_SAVE: begin
				next_savedStatus = statusWord;
				next_savedPc = pcIn;
				// Hardware setting wins over a software write in this cycle
				next_statusWord = statusWord;
				next_statusWord[iat_pkg::SW_BL_BIT] = 1'b1;
				next_statusWord[iat_pkg::SW_MD_BIT] = 1'b1;
				next_statusWord[iat_pkg::SW_RB_BIT] = 1'b1;
				next_cnt = iat_pkg::FETCH_CYCLES - 8'h02;
				next_state = iat_pkg::ST_FETCH;
			end
			iat_pkg::ST_FETCH: begin
				if (cnt == 8'h00) begin
					next_state = iat_pkg::ST_IDLE;
					next_fetchValid = 1'b1;
					next_fetchAddr = vectorBase + iat_pkg::INT_OFFSET;
				end else begin
					next_cnt = cnt - 8'h01;
				end
			end
			default: next_state = iat_pkg::ST_IDLE;
		endcase
		next_saveStrobe = (next_state == iat_pkg::ST_SAVE);
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state <= iat_pkg::ST_IDLE;
			srcHeld <= iat_pkg::SRC_NMI;
			cnt <= 8'h00;
			waitCnt <= 6'h00;
			limit <= 6'h00;
			lastWait <= 6'h00;
			statusWord <= iat_pkg::SW_RESET;
			vectorBase <= iat_pkg::VBASE_RESET;
			savedStatus <= 32'h00000000;
			savedPc <= 32'h00000000;
			fetchAddr <= 32'h00000000;
			fetchValid <= 1'b0;
			saveStrobe <= 1'b0;
		end else begin
			state <= next_state;
			srcHeld <= next_srcHeld;
			cnt <= next_cnt;
			waitCnt <= next_waitCnt;
			limit <= next_limit;
			lastWait <= next_lastWait;
			statusWord <= next_statusWord;
			vectorBase <= next_vectorBase;
			savedStatus <= next_savedStatus;
			savedPc <= next_savedPc;
			fetchAddr <= next_fetchAddr;
			fetchValid <= next_fetchValid;
			saveStrobe <= next_saveStrobe;
		end
	end

	// Checks
	logic [7:0] decideAge;
	always_ff @(posedge core_clk) begin
		if (rst || state != iat_pkg::ST_DECIDE) begin
			decideAge <= 8'h00;
		end else begin
			decideAge <= decideAge + 8'h01;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_save;
		saveStrobe && state == iat_pkg::ST_SAVE;
	endsequence
	sequence s_fetch_gap;
		(!fetchValid)[*4] ##1 fetchValid;
	endsequence

	a_block_holds: assert property (
		(state == iat_pkg::ST_WAITEND && blockFlag)
		|=> state != iat_pkg::ST_SAVE)
		else $error("accepted while block flag set");
	a_decide_time: assert property (
		(state == iat_pkg::ST_DECIDE && next_state != iat_pkg::ST_DECIDE)
		|-> decideAge == decideCycles(srcHeld) - 8'h01)
		else $error("priority decision time wrong");
	a_wait_end: assert property (
		state == iat_pkg::ST_SAVE
		|-> $past(state) == iat_pkg::ST_WAITEND && $past(instrEnds))
		else $error("handling began before instruction end");
	a_wait_bound: assert property (
		(state == iat_pkg::ST_WAITEND && !blockFlag) |-> waitCnt <= limit)
		else $error("instruction wait exceeds bound");
	a_fetch_delay: assert property (
		s_save |-> ##1 s_fetch_gap)
		else $error("handler fetch not five cycles after save");
	a_limit_calc: assert property (
		(state == iat_pkg::ST_DECIDE && next_state == iat_pkg::ST_WAITEND)
		|=> limit == $past(instr.baseStates) + $past(instr.memWait)
			+ $past(instr.extAccesses) - 6'h01 || $past(instr.statusLoad))
		else $error("wait limit ignores memory wait");
	a_load_states: assert property (
		(state == iat_pkg::ST_DECIDE && next_state == iat_pkg::ST_WAITEND
			&& instr.statusLoad && instr.extAccesses == 2'h0
			&& instr.memWait == 4'h0)
		|=> limit == 6'h06)
		else $error("status load not seven states");
	a_mask_gate: assert property (
		(state == iat_pkg::ST_IDLE && next_state == iat_pkg::ST_DECIDE)
		|-> req.level > maskLevel)
		else $error("request taken at or below mask");
	a_save_bits: assert property (
		s_save |=> statusWord[iat_pkg::SW_BL_BIT]
			&& statusWord[iat_pkg::SW_MD_BIT]
			&& statusWord[iat_pkg::SW_RB_BIT]
			&& savedStatus == $past(statusWord) && savedPc == $past(pcIn))
		else $error("save or status bits wrong");
	a_vector_addr: assert property (
		fetchValid |-> fetchAddr == vectorBase + iat_pkg::INT_OFFSET)
		else $error("handler address wrong");
	a_mask_kept: assert property (
		s_save |=> maskLevel == $past(maskLevel))
		else $error("mask level changed by acceptance");
endmodule : iat_interrupt_accept
`default_nettype wire

// >>> rtl/iat_pkg.sv
`default_nettype none
package iat_pkg;
	// Register bus
	localparam int unsigned ADDR_W = 8;
	localparam logic [7:0] OFF_STATUS = 8'h00;
	localparam logic [7:0] OFF_VBASE = 8'h04;
	localparam logic [7:0] OFF_SAVED_SW = 8'h08;
	localparam logic [7:0] OFF_SAVED_PC = 8'h0c;
	localparam logic [7:0] OFF_ACCEPT = 8'h10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Status word layout
	localparam int unsigned SW_BL_BIT = 28;
	localparam int unsigned SW_RB_BIT = 29;
	localparam int unsigned SW_MD_BIT = 30;
	localparam int unsigned SW_IMASK_LSB = 4;
	localparam int unsigned IMASK_W = 4;
	localparam logic [31:0] SW_RESET = 32'h700000f0;
	localparam logic [31:0] VBASE_RESET = 32'h00000000;
	localparam logic [31:0] INT_OFFSET = 32'h00000600;
	// Acceptance status layout
	localparam int unsigned ACC_STATE_LSB = 0;
	localparam int unsigned ACC_WAIT_LSB = 8;
	// Clock ratios, each in CPU cycles
	localparam int unsigned BUS_DIV = 1;
	localparam int unsigned PERI_DIV = 4;
	// Latency terms, HALF_ICYC to HALF_MODULE in half CPU cycles, the rest in whole CPU cycles
	localparam int unsigned HALF_ICYC = 1;
	localparam int unsigned HALF_NMI = BUS_DIV + PERI_DIV;
	localparam int unsigned HALF_LEVEL = BUS_DIV + 4 * PERI_DIV;
	localparam int unsigned HALF_MODULE = 3 * PERI_DIV;
	localparam logic [7:0] FETCH_CYCLES = 8'h05;
	localparam logic [5:0] STATUS_LOAD_STATES = 6'h07;
	localparam logic [5:0] EXT_ACCESS_STATES = 6'h01;

	typedef enum logic [1:0] {
		SRC_NMI = 2'h0,
		SRC_LEVEL = 2'h1,
		SRC_MODULE = 2'h2
	} iat_src_e;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_DECIDE = 3'h1,
		ST_WAITEND = 3'h3,
		ST_SAVE = 3'h2,
		ST_FETCH = 3'h6
	} iat_state_e;

	typedef struct packed {
		logic valid;
		logic [3:0] level;
		iat_src_e source;
	} iat_req_s;

	typedef struct packed {
		logic done;
		logic statusLoad;
		logic [1:0] extAccesses;
		logic [3:0] baseStates;
		logic [3:0] memWait;
	} iat_instr_s;
endpackage : iat_pkg
`default_nettype wire
